// File: rtl/adc_trigger_boundary_check.sv
`timescale 1ns/1ps
module adc_trigger_boundary_check
   import adc_trigger_pkg::*;
#(
   parameter int PERIODIC_TRIGGER_INTERVAL = PERIOD_CYCLES,
   parameter int DELAY_W = 8,
   parameter int GAIN_W = 2,
   parameter int OFFSET_W = 3
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic config_write_unlock,
   input wire logic config_write,
   input wire logic [1:0] new_trigger_source_select,
   input wire logic new_pwm_edge_falling,
   input wire logic [DELAY_W-1:0] new_pwm_trigger_delay,
   input wire logic new_current_source_enable,
   input wire logic [GAIN_W-1:0] new_gain_select,
   input wire logic [OFFSET_W-1:0] new_offset_select,
   input wire logic new_boundary_reaction_enable,
   input wire logic limit_write,
   input wire logic [LIMIT_W-1:0] new_lower_limit_field,
   input wire logic [LIMIT_W-1:0] new_upper_limit_field,
   input wire logic external_trigger_enable,
   input wire logic spi_trigger_command,
   input wire logic clear_status_command,
   input wire logic external_trigger_pin,
   input wire logic pwm_in,
   input wire logic [RESULT_W-1:0] analog_input_pos,
   input wire logic [RESULT_W-1:0] analog_input_neg,
   output logic [RESULT_W-1:0] conversion_result,
   output logic result_valid_flag,
   output logic under_limit_error,
   output logic over_limit_error,
   output logic boundary_violation_status,
   output logic fast_fault_output_n,
   output logic current_source_enable,
   output logic busy
);
   // ---------------------------------------------------------------
   // Configuration
   // ---------------------------------------------------------------
   logic [1:0] trigger_source_select;
   logic pwm_edge_falling;
   logic [DELAY_W-1:0] pwm_trigger_delay;
   logic [GAIN_W-1:0] gain_select;
   logic [OFFSET_W-1:0] offset_select;
   logic boundary_reaction_enable;
   logic [LIMIT_W-1:0] lower_limit_field;
   logic [LIMIT_W-1:0] upper_limit_field;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         trigger_source_select <= TRIG_NONE;
         pwm_edge_falling <= 1'b0;
         pwm_trigger_delay <= '0;
         current_source_enable <= 1'b0;
         gain_select <= '0;
         offset_select <= '0;
         boundary_reaction_enable <= 1'b0;
      end else if (config_write && config_write_unlock) begin
         trigger_source_select <= new_trigger_source_select;
         pwm_edge_falling <= new_pwm_edge_falling;
         pwm_trigger_delay <= new_pwm_trigger_delay;
         current_source_enable <= new_current_source_enable;
         gain_select <= new_gain_select;
         offset_select <= new_offset_select;
         boundary_reaction_enable <= new_boundary_reaction_enable;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lower_limit_field <= LOWER_RESET;
         upper_limit_field <= UPPER_RESET;
      end else if (limit_write && config_write_unlock) begin
         lower_limit_field <= new_lower_limit_field;
         upper_limit_field <= new_upper_limit_field;
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisers and edge detect
   // ---------------------------------------------------------------
   logic [1:0] ext_sync;
   logic ext_last;
   logic [1:0] pwm_sync;
   logic pwm_last;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ext_sync <= 2'h0;
         ext_last <= 1'b0;
         pwm_sync <= 2'h0;
         pwm_last <= 1'b0;
      end else begin
         ext_sync <= {ext_sync[0], external_trigger_pin};
         ext_last <= ext_sync[1];
         pwm_sync <= {pwm_sync[0], pwm_in};
         pwm_last <= pwm_sync[1];
      end
   end

   logic ext_edge;
   logic pwm_edge;
   assign ext_edge = external_trigger_enable && ext_sync[1] && !ext_last;
   assign pwm_edge = pwm_edge_falling ? (pwm_last && !pwm_sync[1])
                                      : (!pwm_last && pwm_sync[1]);

   // ---------------------------------------------------------------
   // Periodic and PWM delay timers
   // ---------------------------------------------------------------
   logic [31:0] period_count;
   logic period_fire;
   assign period_fire = (trigger_source_select == TRIG_PERIODIC)
      && (period_count == 32'(PERIODIC_TRIGGER_INTERVAL - 1));

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         period_count <= 32'h0;
      end else if (trigger_source_select != TRIG_PERIODIC || period_fire) begin
         period_count <= 32'h0;
      end else begin
         period_count <= period_count + 32'h1;
      end
   end

   logic delay_run;
   logic [DELAY_W-1:0] delay_count;
   logic pwm_fire;
   assign pwm_fire = delay_run && (delay_count == pwm_trigger_delay);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         delay_run <= 1'b0;
         delay_count <= '0;
      end else if (trigger_source_select == TRIG_PWM && pwm_edge) begin
         delay_run <= 1'b1;
         delay_count <= '0;
      end else if (pwm_fire || trigger_source_select != TRIG_PWM) begin
         delay_run <= 1'b0;
      end else if (delay_run) begin
         delay_count <= delay_count + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Conversion sequencing
   // ---------------------------------------------------------------
   logic trigger;
   assign trigger = spi_trigger_command || ext_edge || period_fire || pwm_fire;

   function automatic logic [7:0] convert(input logic [7:0] pos, input logic [7:0] neg,
                                          input logic [GAIN_W-1:0] g,
                                          input logic [OFFSET_W-1:0] o);
      logic signed [11:0] diff;
      logic signed [15:0] prod;
      diff = $signed({4'h0, pos}) - $signed({4'h0, neg}) - $signed({9'h000, o});
      prod = 16'(diff) <<< g;
      if (prod < 0) begin
         convert = CODE_MIN;
      end else if (prod > $signed({8'h00, CODE_MAX})) begin
         convert = CODE_MAX;
      end else begin
         convert = prod[7:0];
      end
   endfunction : convert

   conv_state_t state;
   logic [7:0] conv_count;
   logic [7:0] sample;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         conv_count <= 8'h00;
         sample <= 8'h00;
         busy <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (trigger) begin
                  sample <= convert(analog_input_pos, analog_input_neg,
                                    gain_select, offset_select);
                  conv_count <= 8'h00;
                  busy <= 1'b1;
                  state <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (conv_count == 8'(CONV_CYCLES - 1)) begin
                  state <= ST_DONE;
               end else begin
                  conv_count <= conv_count + 8'h01;
               end
            end
            ST_DONE: begin
               busy <= 1'b0;
               state <= ST_IDLE;
            end
            default: begin
               busy <= 1'b0;
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Result, valid flag and boundary check
   // ---------------------------------------------------------------
   logic done;
   logic [7:0] low_thr;
   logic [7:0] high_thr;
   logic below;
   logic above;
   assign done = (state == ST_DONE);
   assign low_thr = {lower_limit_field, LOW_PAD};
   assign high_thr = {upper_limit_field, HIGH_PAD};
   assign below = (sample < low_thr) && (sample < high_thr);
   assign above = (sample > low_thr) && (sample > high_thr);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         conversion_result <= 8'h00;
         result_valid_flag <= 1'b0;
      end else begin
         if (done) begin
            conversion_result <= sample;
         end
         result_valid_flag <= done || (result_valid_flag && !clear_status_command);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         under_limit_error <= 1'b0;
         over_limit_error <= 1'b0;
      end else begin
         under_limit_error <= (done && below) || (under_limit_error && !clear_status_command);
         over_limit_error <= (done && above) || (over_limit_error && !clear_status_command);
      end
   end

   // ---------------------------------------------------------------
   // Boundary status and fast fault output
   // ---------------------------------------------------------------
   logic next_violation;
   assign next_violation = done ? (below || above) : boundary_violation_status;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         boundary_violation_status <= 1'b0;
         fast_fault_output_n <= 1'b1;
      end else begin
         boundary_violation_status <= next_violation;
         if (boundary_reaction_enable && (next_violation != boundary_violation_status)) begin
            fast_fault_output_n <= 1'b0;
         end else if (clear_status_command) begin
            fast_fault_output_n <= 1'b1;
         end
      end
   end
endmodule : adc_trigger_boundary_check

// File: rtl/adc_trigger_pkg.sv
// Overview of operation
// - Each accepted trigger samples the input difference, storing an eight-bit unsigned result.
// - Equal positive and negative inputs give the all-zero code.
// - Completion updates the result and sets valid until the clear-status command.
// - Triggers arriving during a running conversion are dropped, never queued.
// - Primary-side triggers are the SPI trigger command and the external pin.
// - Pin rising edges trigger only while the external-trigger enable is set.
// - The source select field adds periodic or PWM-edge secondary triggers.
// - Periodic mode triggers automatically every periodic trigger interval.
// - PWM mode triggers after the programmed delay from the selected PWM edge.
// - Current-source enable bit drives a fixed current out of the positive input.
// - Gain and offset come from the static select fields.
// - Code equals (difference minus offset) times gain times 255 over reference.
// - Each new result is compared with lower and upper limit fields.
// - Lower limit gets 00 appended, upper limit gets 11 appended.
// - Below both sets under-limit, above both sets over-limit, inside sets neither.
// - Reset limits never raise either boundary error.
// - Boundary reaction enable selects the reaction to boundary events.
// - Config and limit writes take effect only while unlock bit is one.
// - When enabled, boundary status transitions activate the fast fault output.
package adc_trigger_pkg;
   // ---------------------------------------------------------------
   // Trigger source encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] TRIG_NONE = 2'h0;
   localparam logic [1:0] TRIG_PERIODIC = 2'h1;
   localparam logic [1:0] TRIG_PWM = 2'h2;
   // ---------------------------------------------------------------
   // Field layouts and reset values
   // ---------------------------------------------------------------
   localparam int LIMIT_W = 6;
   localparam int RESULT_W = 8;
   localparam logic [1:0] LOW_PAD = 2'h0;
   localparam logic [1:0] HIGH_PAD = 2'h3;
   localparam logic [5:0] LOWER_RESET = 6'h00;
   localparam logic [5:0] UPPER_RESET = 6'h3F;
   localparam logic [7:0] CODE_MAX = 8'hFF;
   localparam logic [7:0] CODE_MIN = 8'h00;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 10000000;
   localparam int CONV_TIME_NS = 1000;
   localparam int CONV_CYCLES = (CONV_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int PERIOD_US = 1000;
   localparam int PERIOD_CYCLES = PERIOD_US * (CLK_HZ / 1000000);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CONV = 3'b010,
      ST_DONE = 3'b100
   } conv_state_t;
endpackage : adc_trigger_pkg

// File: verif/adc_chk.sv
`timescale 1ns/1ps
module adc_chk (
   input wire logic mclk,
   input wire logic rst,
   input wire logic config_write_unlock,
   input wire logic config_write,
   input wire logic new_current_source_enable,
   input wire logic clear_status_command,
   input wire logic [7:0] conversion_result,
   input wire logic result_valid_flag,
   input wire logic under_limit_error,
   input wire logic over_limit_error,
   input wire logic boundary_violation_status,
   input wire logic fast_fault_output_n,
   input wire logic current_source_enable,
   input wire logic busy
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_run; busy[*8] ##1 busy[*3]; endsequence
   sequence s_end; !busy && result_valid_flag; endsequence
   AST_CONV_LEN: assert property ($rose(busy) |-> s_run ##1 s_end)
      else $error("conversion length wrong");
   AST_RES_HOLD: assert property (busy |-> $stable(conversion_result))
      else $error("result moved during conversion");
   AST_VALID_HOLD: assert property (result_valid_flag && !clear_status_command |=>
      result_valid_flag) else $error("valid flag dropped");
   AST_CLEAR: assert property (clear_status_command && !busy |=> !result_valid_flag
      && !under_limit_error && !over_limit_error) else $error("clear ignored");
   AST_UNDER: assert property ($rose(under_limit_error) |-> $fell(busy))
      else $error("under flag outside completion");
   AST_OVER: assert property ($rose(over_limit_error) |-> $fell(busy))
      else $error("over flag outside completion");
   AST_STATUS: assert property ($changed(boundary_violation_status) |-> $fell(busy))
      else $error("status moved outside completion");
   AST_CSRC: assert property (config_write && config_write_unlock |=>
      current_source_enable == $past(new_current_source_enable)) else $error("csrc not set");
   AST_LOCK: assert property (config_write && !config_write_unlock |=>
      $stable(current_source_enable)) else $error("locked write took effect");
   AST_FAULT: assert property ($fell(fast_fault_output_n) |->
      $changed(boundary_violation_status)) else $error("fault without status change");
endmodule : adc_chk
bind adc_trigger_boundary_check adc_chk u_chk (.*);

// File: verif/host_model.sv
`timescale 1ns/1ps
module host_model (
   input wire logic mclk,
   output logic spi_trigger_command,
   output logic clear_status_command,
   output logic external_trigger_pin
);
   initial {spi_trigger_command, clear_status_command, external_trigger_pin} = 3'h0;
   task automatic trig(input logic pin, input int w);
      @(negedge mclk);
      if (pin) external_trigger_pin = 1'h1;
      else spi_trigger_command = 1'h1;
      repeat (w) @(negedge mclk);
      {spi_trigger_command, external_trigger_pin} = 2'h0;
   endtask : trig
   task automatic clr();
      @(negedge mclk);
      clear_status_command = 1'h1;
      @(negedge mclk);
      clear_status_command = 1'h0;
   endtask : clr
endmodule : host_model

// File: verif/test_adc_trigger_boundary_check.sv
`timescale 1ns/1ps
module test_adc_trigger_boundary_check;
   import adc_trigger_pkg::*;
   typedef struct packed {logic [7:0] r; logic u; logic o; logic f;} note_t;
   logic mclk = 0, rst = 1, config_write_unlock = 1, config_write = 0, limit_write = 0;
   logic new_pwm_edge_falling = 0, new_current_source_enable = 0, pwm_in = 0;
   logic new_boundary_reaction_enable = 0, external_trigger_enable = 0, pst = 0, pb = 0;
   logic result_valid_flag, under_limit_error, over_limit_error, boundary_violation_status;
   logic fast_fault_output_n, current_source_enable, busy;
   logic spi_trigger_command, clear_status_command, external_trigger_pin;
   logic [1:0] new_trigger_source_select = 0, new_gain_select = 0;
   logic [2:0] new_offset_select = 0;
   logic [5:0] new_lower_limit_field = 0, new_upper_limit_field = 6'h3F;
   logic [7:0] new_pwm_trigger_delay = 8'h05, analog_input_pos = 0, analog_input_neg = 0;
   logic [7:0] conversion_result;
   note_t q[$];
   note_t n;
   int fails = 0, tests_run = 0, seed = 82912;
   always #50 mclk = ~mclk;
   adc_trigger_boundary_check #(.PERIODIC_TRIGGER_INTERVAL(20)) DUT (.*);
   host_model host (.*);
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
      tests_run++;
      if (e !== v) begin
         fails++;
         $display("FAIL %s expected %h seen %h", s, e, v);
      end
   endtask : chk
   task automatic close_out();
      $display("fails %0d tests_run %0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   function automatic note_t calc();
      int v;
      note_t t;
      v = (int'(analog_input_pos) - int'(analog_input_neg) - int'(new_offset_select));
      v = v <<< new_gain_select;
      t.r = (v < 0) ? 8'h00 : (v > 255) ? 8'hFF : v[7:0];
      t.u = t.r < {new_lower_limit_field, 2'h0};
      t.o = t.r > {new_upper_limit_field, 2'h3};
      t.f = !(new_boundary_reaction_enable && ((t.u | t.o) != pst));
      pst = t.u | t.o;
      return t;
   endfunction : calc
   task automatic cfg();
      @(negedge mclk);
      {config_write, limit_write} = 2'h3;
      @(negedge mclk);
      {config_write, limit_write} = 2'h0;
   endtask : cfg
   task automatic waitq();
      int k;
      for (k = 0; k < 200 && q.size() > 0; k++) @(negedge mclk);
      if (q.size() > 0) begin
         chk("timeout", 8'h00, 8'h01);
         close_out();
      end
   endtask : waitq
   task automatic conv(input logic pin, input int w);
      q.push_back(calc());
      host.trig(pin, w);
      waitq();
      host.clr();
   endtask : conv
   // ---------------------------------------------------------------
   // Result monitor
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      #1;
      if (pb && !busy) begin
         if (q.size() == 0) chk("extra result", 8'h00, 8'h01);
         else begin
            n = q.pop_front();
            chk("result", n.r, conversion_result);
            chk("valid", 8'h01, result_valid_flag);
            chk("under", n.u, under_limit_error);
            chk("over", n.o, over_limit_error);
            chk("fault_n", n.f, fast_fault_output_n);
         end
      end
      pb = busy;
   end
   initial begin
      repeat (6) @(negedge mclk);
      rst = 0;
      analog_input_pos = 8'hFF;
      conv(0, 1);
      analog_input_pos = 8'h00;
      conv(0, 1);
      {new_lower_limit_field, new_upper_limit_field} = {6'h08, 6'h30};
      {new_boundary_reaction_enable, external_trigger_enable} = 2'h3;
      for (int i = 0; i < 16; i++) begin
         {new_gain_select, new_offset_select} = {i[1:0], i[3:1]};
         cfg();
         {analog_input_pos, analog_input_neg} = 16'($random(seed));
         conv(i[0], (i == 4) ? 3 : 4);
      end
      {config_write_unlock, new_current_source_enable} = 2'h1;
      cfg();
      chk("csrc locked", 8'h00, current_source_enable);
      config_write_unlock = 1'h1;
      cfg();
      chk("csrc", 8'h01, current_source_enable);
      external_trigger_enable = 1'h0;
      host.trig(1, 4);
      {new_lower_limit_field, new_upper_limit_field} = {6'h00, 6'h3F};
      {new_boundary_reaction_enable, new_trigger_source_select} = 3'h1;
      repeat (4) q.push_back(calc());
      cfg();
      repeat (78) @(negedge mclk);
      new_trigger_source_select = 2'h0;
      cfg();
      waitq();
      host.clr();
      new_trigger_source_select = 2'h2;
      for (int e = 0; e < 2; e++) begin
         new_pwm_edge_falling = e[0];
         cfg();
         q.push_back(calc());
         pwm_in = !e[0];
         waitq();
         host.clr();
      end
      repeat (30) @(negedge mclk);
      close_out();
   end
endmodule : test_adc_trigger_boundary_check
